// ===== verilog/sgp_consts.svh
// Register indices, field positions, reset values and mode codes of the pin control block
`ifndef SGP_CONSTS_SVH
`define SGP_CONSTS_SVH

`define SGP_ADDR_W        8
`define SGP_IDX_CFG12     6'h0E
`define SGP_IDX_CFG3      6'h0F
`define SGP_IDX_CFG56     6'h10
`define SGP_IDX_CTRL      6'h20
`define SGP_IDX_STAT      6'h21

`define SGP_LO_MODE_LSB   0
`define SGP_LO_VAL_BIT    3
`define SGP_HI_MODE_LSB   4
`define SGP_HI_VAL_BIT    7
`define SGP_CFG56_WMASK   8'hBB
`define SGP_CFG3_WMASK    4'hF
`define SGP_CFG_RST       8'h00
`define SGP_CFG3_RST      4'h0
`define SGP_CTRL_PSEL_BIT 0

`define SGP_MODE_OUT      3'h1
`define SGP_MODE_IN       3'h3
`define SGP_MODE_RHOLD    3'h5
`define SGP_MODE_RDFLT    3'h7
`define SGP_LOW_FUNC      2'h0
`define SGP_LOW_HIZ       2'h2
`define SGP_MODE2_OUT     2'h1

`define SGP_RESP_OKAY     2'h0
`define SGP_RESP_SLVERR   2'h2

`endif

// ===== verilog/sgp_pkg.sv
// Types of the pin control block: bus state machines and the registered state
package sgp_pkg;

	typedef enum logic [1:0] {
		SGP_WR_IDLE = 2'h1,
		SGP_WR_RESP = 2'h2
	} sgp_wr_st_t;

	typedef enum logic [1:0] {
		SGP_RD_IDLE = 2'h1,
		SGP_RD_DATA = 2'h2
	} sgp_rd_st_t;

	typedef struct packed {
		logic [1:0][7:0] cfg12;
		logic [1:0][3:0] cfg3;
		logic [7:0]      cfg56;
		logic            port_sel;
		logic [1:0][2:0] rmt;
		logic [5:0]      rpo;
		logic [5:0]      rpoe;
		logic [1:0]      lpo;
		logic [1:0]      lpoe;
		sgp_wr_st_t      wr_st;
		logic            aw_got;
		logic            w_got;
		logic [5:0]      awidx;
		logic [7:0]      wdata;
		logic            wstrb0;
		logic            awready;
		logic            wready;
		logic            bvalid;
		logic [1:0]      bresp;
		sgp_rd_st_t      rd_st;
		logic            arready;
		logic            rvalid;
		logic [31:0]     rdata;
		logic [1:0]      rresp;
	} sgp_state_t;

endpackage

// ===== verilog/sgp_pin_ctrl.sv
// Pin configuration, remote pin drive and AXI4-Lite register slave of the link transmitter
`timescale 1ns/1ps
`include "sgp_consts.svh"

module sgp_pin_ctrl
	import sgp_pkg::*;
#(
	parameter int ADDR_W = `SGP_ADDR_W
)
(
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic                    ce,
	input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
	input  wire logic [2:0]              s_axi_awprot,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [ADDR_W-1:0]       s_axi_araddr,
	input  wire logic [2:0]              s_axi_arprot,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic [1:0]              link_up,
	input  wire logic                    bc_valid,
	input  wire logic                    bc_port,
	input  wire logic [2:0]              bc_value,
	input  wire logic [5:0]              rpin_i,
	output logic [5:0]                   rpin_o,
	output logic [5:0]                   rpin_oe,
	input  wire logic [1:0]              lpin_i,
	output logic [1:0]                   lpin_o,
	output logic [1:0]                   lpin_oe
);

	sgp_state_t s_ff;
	sgp_state_t nxt_s;
	sgp_state_t rst_s;

	logic [5:0] drv_o;
	logic [5:0] drv_oe;
	logic [1:0] ldrv_o;
	logic [1:0] ldrv_oe;

	// Index decode uses address bits 7:2, so a narrower bus cannot reach the registers
	generate
		if (ADDR_W < `SGP_ADDR_W) begin : g_chk_addr
			$error("sgp_pin_ctrl: ADDR_W below 8 cannot reach every register");
		end
	endgenerate

	// Remote-capable pins: index = port * 3 + pin
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : g_rpin
			localparam int PORT = gi / 3;
			localparam int PIN  = gi % 3;
			logic [2:0] mode;
			logic       lval;
			logic       rval;
			if (PIN == 0) begin : g_p1
				assign mode = s_ff.cfg12[PORT][`SGP_LO_MODE_LSB+:3];
				assign lval = s_ff.cfg12[PORT][`SGP_LO_VAL_BIT];
			end else if (PIN == 1) begin : g_p2
				assign mode = s_ff.cfg12[PORT][`SGP_HI_MODE_LSB+:3];
				assign lval = s_ff.cfg12[PORT][`SGP_HI_VAL_BIT];
			end else begin : g_p3
				assign mode = s_ff.cfg3[PORT][`SGP_LO_MODE_LSB+:3];
				assign lval = s_ff.cfg3[PORT][`SGP_LO_VAL_BIT];
			end
			assign rval = s_ff.rmt[PORT][PIN];
			always_comb begin
				drv_o[gi]  = 1'b0;
				drv_oe[gi] = 1'b0;
				case (mode)
					`SGP_MODE_OUT: begin
						drv_o[gi]  = lval;
						drv_oe[gi] = 1'b1;
					end
					`SGP_MODE_IN: begin
						drv_oe[gi] = 1'b0;
					end
					`SGP_MODE_RHOLD: begin
						drv_o[gi]  = rval;
						drv_oe[gi] = 1'b1;
					end
					`SGP_MODE_RDFLT: begin
						drv_o[gi]  = link_up[PORT] ? rval : lval;
						drv_oe[gi] = 1'b1;
					end
					default: begin
						// Low bits 00 functional input, 10 high impedance
						drv_oe[gi] = 1'b0;
					end
				endcase
			end
		end
		// Pins five and six: two-bit mode, local value only
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_lpin
			localparam int MLSB = (gi == 0) ? `SGP_LO_MODE_LSB : `SGP_HI_MODE_LSB;
			localparam int VBIT = (gi == 0) ? `SGP_LO_VAL_BIT : `SGP_HI_VAL_BIT;
			always_comb begin
				ldrv_oe[gi] = 1'b0;
				ldrv_o[gi]  = 1'b0;
				case (s_ff.cfg56[MLSB+:2])
					`SGP_MODE2_OUT: begin
						ldrv_oe[gi] = 1'b1;
						ldrv_o[gi]  = s_ff.cfg56[VBIT];
					end
					default: begin
						// Functional input, high impedance or input: not driven
						ldrv_oe[gi] = 1'b0;
					end
				endcase
			end
		end
	endgenerate

	function automatic logic [31:0] rd_word(input sgp_state_t st, input logic [5:0] idx);
		logic p;
		p = st.port_sel;
		rd_word = 32'h0000_0000;
		case (idx)
			`SGP_IDX_CFG12: rd_word = {24'h00_0000, st.cfg12[p]};
			`SGP_IDX_CFG3:  rd_word = {28'h000_0000, st.cfg3[p]};
			`SGP_IDX_CFG56: rd_word = {24'h00_0000, st.cfg56};
			`SGP_IDX_CTRL:  rd_word = {31'h0000_0000, st.port_sel};
			`SGP_IDX_STAT: begin
				// Pin levels, latched remote values and link state
				rd_word = {16'h0000, lpin_i, rpin_i, st.rmt[1], st.rmt[0], link_up};
			end
			default:        rd_word = 32'h0000_0000;
		endcase
	endfunction

	// Mapped indices; anything else answers SLVERR
	function automatic logic idx_hit(input logic [5:0] idx);
		idx_hit = (idx == `SGP_IDX_CFG12) || (idx == `SGP_IDX_CFG3) || (idx == `SGP_IDX_CFG56)
			|| (idx == `SGP_IDX_CTRL) || (idx == `SGP_IDX_STAT);
	endfunction

	always_comb begin
		rst_s          = '0;
		rst_s.cfg12[0] = `SGP_CFG_RST;
		rst_s.cfg12[1] = `SGP_CFG_RST;
		rst_s.cfg3[0]  = `SGP_CFG3_RST;
		rst_s.cfg3[1]  = `SGP_CFG3_RST;
		rst_s.cfg56    = `SGP_CFG_RST;
		rst_s.wr_st    = SGP_WR_IDLE;
		rst_s.rd_st    = SGP_RD_IDLE;
	end

	logic       aw_hs;
	logic       w_hs;
	logic       have_aw;
	logic       have_w;
	logic [5:0] widx;
	logic [7:0] wbyte;
	logic       wen;
	logic       p_sel;

	always_comb begin
		nxt_s   = s_ff;
		aw_hs   = s_axi_awvalid & s_ff.awready;
		w_hs    = s_axi_wvalid & s_ff.wready;
		have_aw = s_ff.aw_got | aw_hs;
		have_w  = s_ff.w_got | w_hs;
		widx    = s_ff.aw_got ? s_ff.awidx : s_axi_awaddr[7:2];
		wbyte   = s_ff.w_got ? s_ff.wdata : s_axi_wdata[7:0];
		wen     = s_ff.w_got ? s_ff.wstrb0 : s_axi_wstrb[0];
		p_sel   = s_ff.port_sel;

		// Write channel: address and data in either order, response after both
		case (s_ff.wr_st)
			SGP_WR_IDLE: begin
				if (aw_hs) begin
					nxt_s.aw_got = 1'b1;
					nxt_s.awidx  = s_axi_awaddr[7:2];
				end
				if (w_hs) begin
					nxt_s.w_got  = 1'b1;
					nxt_s.wdata  = s_axi_wdata[7:0];
					nxt_s.wstrb0 = s_axi_wstrb[0];
				end
				// Each ready drops once its half is held
				nxt_s.awready = ~have_aw;
				nxt_s.wready  = ~have_w;
				if (have_aw && have_w) begin
					nxt_s.aw_got  = 1'b0;
					nxt_s.w_got   = 1'b0;
					nxt_s.awready = 1'b0;
					nxt_s.wready  = 1'b0;
					nxt_s.bvalid  = 1'b1;
					// Unmapped index answers SLVERR and leaves the registers alone
					nxt_s.bresp   = idx_hit(widx) ? `SGP_RESP_OKAY : `SGP_RESP_SLVERR;
					nxt_s.wr_st   = SGP_WR_RESP;
					if (wen) begin
						case (widx)
							`SGP_IDX_CFG12: nxt_s.cfg12[p_sel] = wbyte;
							`SGP_IDX_CFG3:  nxt_s.cfg3[p_sel] = wbyte[3:0] & `SGP_CFG3_WMASK;
							`SGP_IDX_CFG56: nxt_s.cfg56 = wbyte & `SGP_CFG56_WMASK;
							`SGP_IDX_CTRL:  nxt_s.port_sel = wbyte[`SGP_CTRL_PSEL_BIT];
							default: begin
							end
						endcase
					end
				end
			end
			SGP_WR_RESP: begin
				if (s_axi_bready) begin
					nxt_s.bvalid  = 1'b0;
					nxt_s.bresp   = `SGP_RESP_OKAY;
					nxt_s.awready = 1'b1;
					nxt_s.wready  = 1'b1;
					nxt_s.wr_st   = SGP_WR_IDLE;
				end
			end
			default: begin
				nxt_s.wr_st = SGP_WR_IDLE;
			end
		endcase

		// Read channel
		case (s_ff.rd_st)
			SGP_RD_IDLE: begin
				nxt_s.arready = 1'b1;
				if (s_axi_arvalid && s_ff.arready) begin
					nxt_s.arready = 1'b0;
					nxt_s.rvalid  = 1'b1;
					// Data taken from the state before this edge
					nxt_s.rdata   = rd_word(s_ff, s_axi_araddr[7:2]);
					nxt_s.rresp   = idx_hit(s_axi_araddr[7:2]) ? `SGP_RESP_OKAY : `SGP_RESP_SLVERR;
					nxt_s.rd_st   = SGP_RD_DATA;
				end
			end
			SGP_RD_DATA: begin
				if (s_axi_rready) begin
					nxt_s.rvalid  = 1'b0;
					nxt_s.rdata   = 32'h0000_0000;
					nxt_s.rresp   = `SGP_RESP_OKAY;
					nxt_s.arready = 1'b1;
					nxt_s.rd_st   = SGP_RD_IDLE;
				end
			end
			default: begin
				nxt_s.rd_st = SGP_RD_IDLE;
			end
		endcase

		// Remote values latched only from a valid frame on a linked port
		if (bc_valid && link_up[bc_port]) begin
			nxt_s.rmt[bc_port] = bc_value;
		end

		nxt_s.rpo  = drv_o;
		nxt_s.rpoe = drv_oe;
		nxt_s.lpo  = ldrv_o;
		nxt_s.lpoe = ldrv_oe;
	end

	always_ff @(posedge aclk) begin
		// Reset is taken even while ce is low
		if (!aresetn) begin
			s_ff <= rst_s;
		end else if (ce) begin
			s_ff <= nxt_s;
		end
	end

	// Every output comes straight from a register
	assign s_axi_awready = s_ff.awready;
	assign s_axi_wready  = s_ff.wready;
	assign s_axi_bvalid  = s_ff.bvalid;
	assign s_axi_bresp   = s_ff.bresp;
	assign s_axi_arready = s_ff.arready;
	assign s_axi_rvalid  = s_ff.rvalid;
	assign s_axi_rdata   = s_ff.rdata;
	assign s_axi_rresp   = s_ff.rresp;
	assign rpin_o        = s_ff.rpo;
	assign rpin_oe       = s_ff.rpoe;
	assign lpin_o        = s_ff.lpo;
	assign lpin_oe       = s_ff.lpoe;

endmodule

// ===== verif/sgp_pin_ctrl_props.sv
// Concurrent checks on the ports of the pin control block
`timescale 1ns/1ps

module sgp_pin_ctrl_props (
	input logic        aclk,
	input logic        aresetn,
	input logic        s_axi_awvalid,
	input logic        s_axi_awready,
	input logic        s_axi_wvalid,
	input logic        s_axi_wready,
	input logic [1:0]  s_axi_bresp,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	input logic [1:0]  link_up,
	input logic        bc_valid,
	input logic [5:0]  rpin_o,
	input logic [5:0]  rpin_oe,
	input logic [1:0]  lpin_o,
	input logic [1:0]  lpin_oe
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_rst;
		disable iff (1'b0) !aresetn |=> !rpin_oe && !lpin_oe && !s_axi_bvalid && !s_axi_rvalid;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");

	// Pins move only after a frame, a write or a link change
	property p_quiet;
		($stable(link_up) && $past(link_up) == $past(link_up, 2) && !$past(bc_valid)
			&& !$past(bc_valid, 2) && !$past(s_axi_bvalid)) |-> $stable({rpin_o, rpin_oe, lpin_o, lpin_oe});
	endproperty
	a_quiet: assert property (p_quiet) else $error("pin changed without cause");

	property p_bone;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid && !s_axi_awready;
	endproperty
	a_bone: assert property (p_bone) else $error("write response late");

	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");

	property p_bback;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
	endproperty
	a_bback: assert property (p_bback) else $error("write readies not back");

	property p_rone;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rone: assert property (p_rone) else $error("read data late");

	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");

	property p_hi;
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0;
	endproperty
	a_hi: assert property (p_hi) else $error("upper read bits set");
endmodule

bind sgp_pin_ctrl sgp_pin_ctrl_props i_sgp_pin_ctrl_props (.*);

// ===== verif/sgp_rmt_model.sv
// Far-end receiver model sending back-channel pin frames
`timescale 1ns/1ps

module sgp_rmt_model (
	input  logic       aclk,
	input  logic       send,
	input  logic       port,
	input  logic [2:0] val,
	output logic       bc_valid,
	output logic       bc_port,
	output logic [2:0] bc_value
);
	initial bc_valid = 1'b0;
	initial bc_port = 1'b0;
	initial bc_value = 3'h0;
	// One-cycle frame; value toggles between frames
	always @(posedge aclk) begin
		bc_valid <= send;
		if (send) begin
			bc_port  <= port;
			bc_value <= val;
		end else begin
			bc_value <= ~bc_value;
		end
	end
endmodule

// ===== verif/sgp_pin_ctrl_tb.sv
// Random and corner tests of the pin control block
`timescale 1ns/1ps
`include "sgp_consts.svh"

`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_mismatch++; \
	$display("[ERR] %s exp %h got %h", n, e, s); end end

module sgp_pin_ctrl_tb;
	logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
	logic        send = 0, sport = 0, en = 1, p, awr, wrd, bv, arr, rv, bcv, bcp;
	logic [7:0]  awa = 0, ara = 0, c56 = 0;
	logic [3:0]  ws = 4'hF;
	logic [31:0] wd = 0, rdt;
	logic [1:0]  lnk = 0, br, rr, lo, loe, lpi = 0;
	logic [2:0]  sval = 0, bcd;
	logic [5:0]  ro, roe, rpi = 0;
	logic [7:0]  c12[2] = '{8'h0, 8'h0};
	logic [3:0]  c3[2] = '{4'h0, 4'h0};
	logic [2:0]  rem[2] = '{3'h0, 3'h0};
	int          n_mismatch = 0, n_compared = 0;

	initial forever #2.5 aclk = ~aclk;

	sgp_pin_ctrl i_sgp_pin_ctrl (.aclk, .aresetn, .ce(en), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bready),
		.s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rready), .link_up(lnk),
		.bc_valid(bcv), .bc_port(bcp), .bc_value(bcd), .rpin_i(rpi), .rpin_o(ro), .rpin_oe(roe),
		.lpin_i(lpi), .lpin_o(lo), .lpin_oe(loe));

	sgp_rmt_model i_sgp_rmt_model (.aclk, .send, .port(sport), .val(sval), .bc_valid(bcv),
		.bc_port(bcp), .bc_value(bcd));

	function automatic logic [1:0] ep(input logic [3:0] n, input logic r, input logic l);
		case (n[2:0])
			`SGP_MODE_OUT:   ep = {1'b1, n[3]};
			`SGP_MODE_RHOLD: ep = {1'b1, r};
			`SGP_MODE_RDFLT: ep = {1'b1, l ? r : n[3]};
			default:         ep = 2'h0;
		endcase
	endfunction

	task automatic wr(input logic [5:0] i, input logic [7:0] d, input logic [1:0] er = `SGP_RESP_OKAY);
		logic a = 0;
		logic w = 0;
		@(posedge aclk);
		awa <= {i, 2'h0};
		wd <= {24'h0, d};
		awv <= 1;
		wv <= 1;
		bready <= 1;
		while (!(a && w)) begin
			@(posedge aclk);
			if (awv && awr) begin
				a = 1;
				awv <= 0;
			end
			if (wv && wrd) begin
				w = 1;
				wv <= 0;
			end
		end
		do @(posedge aclk); while (!bv);
		`CHK("bresp", er, br)
		bready <= 0;
	endtask

	task automatic rd(input logic [5:0] i, input logic [31:0] e, input logic [1:0] er = `SGP_RESP_OKAY);
		@(posedge aclk);
		ara <= {i, 2'h0};
		arv <= 1;
		rready <= 1;
		do @(posedge aclk); while (!arr);
		arv <= 0;
		do @(posedge aclk); while (!rv);
		`CHK("rdata", e, rdt)
		`CHK("rresp", er, rr)
		rready <= 0;
	endtask

	task automatic pins;
		logic [3:0] n;
		for (int k = 0; k < 6; k++) begin
			n = k % 3 == 0 ? c12[k/3][3:0] : k % 3 == 1 ? c12[k/3][7:4] : c3[k/3];
			`CHK("rpin", ep(n, rem[k/3][k%3], lnk[k/3]), {roe[k], roe[k] & ro[k]})
		end
		for (int k = 0; k < 2; k++) begin
			n = k ? c56[7:4] : c56[3:0];
			`CHK("lpin", n[1:0] == 2'h1 ? {1'b1, n[3]} : 2'h0, {loe[k], loe[k] & lo[k]})
		end
	endtask

	task automatic test_done;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		#100000;
		n_mismatch++;
		test_done;
	end

	initial begin
		void'($urandom(32'hED9D));
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		pins;
		for (int i = 14; i < 17; i++)
			rd(6'(i), 32'h0);
		ws <= 4'h0;
		wr(`SGP_IDX_CFG12, 8'hFF);
		ws <= 4'hF;
		rd(`SGP_IDX_CFG12, 32'h0);
		wr(6'h30, 8'hFF, `SGP_RESP_SLVERR);
		rd(6'h30, 32'h0, `SGP_RESP_SLVERR);
		wr(`SGP_IDX_STAT, 8'hFF);
		rd(`SGP_IDX_STAT, 32'h0);
		$display("corner test done");
		repeat (24) begin
			p = 1'($urandom);
			lnk <= 2'($urandom);
			rpi <= 6'($urandom);
			lpi <= 2'($urandom);
			wr(`SGP_IDX_CTRL, {7'h0, p});
			c12[p] = 8'($urandom);
			c3[p] = 4'($urandom);
			c56 = 8'($urandom) & `SGP_CFG56_WMASK;
			wr(`SGP_IDX_CFG12, c12[p]);
			wr(`SGP_IDX_CFG3, {4'hF, c3[p]});
			wr(`SGP_IDX_CFG56, c56 | 8'h44);
			rd(`SGP_IDX_CFG12, {24'h0, c12[p]});
			rd(`SGP_IDX_CFG3, {28'h0, c3[p]});
			rd(`SGP_IDX_CFG56, {24'h0, c56});
			@(posedge aclk);
			send <= 1;
			en <= 1'($urandom);
			sport <= 1'($urandom);
			sval <= 3'($urandom);
			@(posedge aclk);
			send <= 0;
			if (lnk[sport] && en)
				rem[sport] = sval;
			@(posedge aclk);
			en <= 1;
			repeat (2) @(posedge aclk);
			pins;
			rd(`SGP_IDX_STAT, {16'h0, lpi, rpi, rem[1], rem[0], lnk});
		end
		$display("random test done");
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		c12 = '{8'h0, 8'h0};
		c3 = '{4'h0, 4'h0};
		c56 = 8'h0;
		rem = '{3'h0, 3'h0};
		repeat (2) @(posedge aclk);
		pins;
		rd(`SGP_IDX_CTRL, 32'h0);
		rd(`SGP_IDX_STAT, {16'h0, lpi, rpi, 6'h0, lnk});
		$display("reset test done");
		test_done;
	end
endmodule
